// ### modulo_timer_pkg.sv
`default_nettype none
package modulo_timer_pkg;

  // ************************************************************
  // register map and field layout
  // ************************************************************
  localparam int REG_W = 8;                    // register width
  localparam int ADDR_W = 2;                   // register address width
  localparam logic [1:0] OFS_STATUS = 2'h0;    // timer_status_control
  localparam logic [1:0] OFS_CLOCK = 2'h1;     // timer_clock_config
  localparam logic [1:0] OFS_COUNT = 2'h2;     // timer_count_value
  localparam logic [1:0] OFS_MODULO = 2'h3;    // timer_modulo_limit

  localparam int BIT_OVF = 7;                  // overflow_flag
  localparam int BIT_IRQ_EN = 6;               // overflow_irq_enable
  localparam int BIT_CLEAR = 5;                // counter clear strobe
  localparam int BIT_HALT = 4;                 // count_halt
  localparam int SRC_HI = 5;                   // source_select msb
  localparam int SRC_LO = 4;                   // source_select lsb
  localparam int PS_HI = 3;                    // prescale_select msb
  localparam int PS_LO = 0;                    // prescale_select lsb

  // ************************************************************
  // encodings and reset values
  // ************************************************************
  localparam logic [1:0] SRC_BUS = 2'h0;       // system bus clock
  localparam logic [1:0] SRC_FIXED = 2'h1;     // fixed frequency clock
  localparam logic [1:0] SRC_PIN_FALL = 2'h2;  // pin falling edge
  localparam logic [1:0] SRC_PIN_RISE = 2'h3;  // pin rising edge
  localparam logic [3:0] PS_MAX = 4'h8;        // divide by 256
  localparam logic RST_HALT = 1'b1;
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic [1:0] RST_SRC = 2'h0;
  localparam logic [3:0] RST_PS = 4'h0;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_MODULO = 8'h00;
  localparam logic [7:0] FREE_LIMIT = 8'hFF;   // wrap point when modulo is zero

  // flag clearing sequence states
  typedef enum logic [1:0] {
    CLR_IDLE = 2'b01,
    CLR_ARMED = 2'b10
  } clear_state_t;

  // ************************************************************
  // shared arithmetic
  // ************************************************************
  // low prescaler bits that must all be ones for a tick
  function automatic logic [7:0] prescale_mask(input logic [3:0] sel);
    logic [8:0] t;
    t = 9'h001;
    if (sel >= PS_MAX) begin
      prescale_mask = 8'hFF;
    end else begin
      t = 9'h001 << sel;
      prescale_mask = t[7:0] - 8'h01;
    end
  endfunction : prescale_mask

  // value after which the counter wraps to zero
  function automatic logic [7:0] count_limit(input logic [7:0] modulo);
    count_limit = (modulo == 8'h00) ? FREE_LIMIT : modulo;
  endfunction : count_limit

endpackage : modulo_timer_pkg
`default_nettype wire

// ### edge_sync.sv
`default_nettype none
module edge_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic rise_pulse,
  output logic fall_pulse
);

  // ************************************************************
  // two stage synchroniser and edge detect
  // ************************************************************
  logic sync_a;       // first stage, read only by sync_b
  logic sync_b;       // second stage, safe level
  logic prev_b;       // delayed safe level
  logic next_sync_a;
  logic next_sync_b;
  logic next_prev_b;

  // next values of the shift chain
  always_comb begin
    next_sync_a = async_in;
    next_sync_b = sync_a;
    next_prev_b = sync_b;
  end

  // register the chain
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev_b <= 1'b0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      prev_b <= next_prev_b;
    end
  end

  // one cycle pulses on each edge
  assign rise_pulse = sync_b & ~prev_b;
  assign fall_pulse = ~sync_b & prev_b;

endmodule : edge_sync
`default_nettype wire

// ### prescaler.sv
`default_nettype none
module prescaler
  import modulo_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic src_tick,
  input wire logic run,
  input wire logic clear,
  input wire logic [3:0] select,
  output logic tick_out
);

  // ************************************************************
  // 8-bit ripple divider with tap select
  // ************************************************************
  logic [7:0] div_count;       // source ticks seen
  logic [7:0] next_div_count;
  logic [7:0] mask;            // taps for the chosen ratio

  // advance on each source tick while running
  always_comb begin
    mask = prescale_mask(select);
    next_div_count = div_count;
    if (clear) begin
      next_div_count = 8'h00;
    end else if (run && src_tick) begin
      next_div_count = div_count + 8'h01;
    end
  end

  // register the divider
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_count <= 8'h00;
    end else begin
      div_count <= next_div_count;
    end
  end

  // tick when all selected low bits are ones; ratio change keeps the count
  assign tick_out = run && src_tick && ((div_count & mask) == mask);

endmodule : prescaler
`default_nettype wire

// ### modulo_timer.sv
`default_nettype none
module modulo_timer
  import modulo_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ext_count_pin,
  input wire logic fixed_freq_clock,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic overflow_irq
);

  // ************************************************************
  // register state
  // ************************************************************
  logic overflow_flag;            // sticky overflow
  logic overflow_irq_enable;      // interrupt gate
  logic count_halt;               // counter frozen
  logic [1:0] source_select;      // count source
  logic [3:0] prescale_select;    // division ratio
  logic [7:0] count;              // timer count
  logic [7:0] modulo;             // wrap value
  clear_state_t clear_state;      // flag clearing progress
  logic [7:0] rdata;              // registered read data
  logic irq;                      // registered interrupt

  logic next_overflow_flag;
  logic next_overflow_irq_enable;
  logic next_count_halt;
  logic [1:0] next_source_select;
  logic [3:0] next_prescale_select;
  logic [7:0] next_count;
  logic [7:0] next_modulo;
  clear_state_t next_clear_state;
  logic [7:0] next_rdata;
  logic next_irq;

  // ************************************************************
  // decode and count sources
  // ************************************************************
  logic wr_status;                // write to status register
  logic wr_clock;                 // write to clock register
  logic wr_modulo;                // write to modulo register
  logic rd_status;                // read of status register
  logic count_clear;              // counter reset this cycle
  logic pin_rise;                 // synced pin rising edge
  logic pin_fall;                 // synced pin falling edge
  logic fixed_rise;               // synced fixed clock edge
  logic src_tick;                 // selected source enable
  logic presc_tick;               // prescaled count enable
  logic overflow_event;           // wrap to zero this cycle
  logic clear_seq;                // second step of flag clear

  // strobes qualified by address; count register writes decode to nothing
  always_comb begin
    wr_status = reg_wr && (reg_addr == OFS_STATUS);
    wr_clock = reg_wr && (reg_addr == OFS_CLOCK);
    wr_modulo = reg_wr && (reg_addr == OFS_MODULO);
    rd_status = reg_rd && (reg_addr == OFS_STATUS);
    count_clear = (wr_status && reg_wdata[BIT_CLEAR]) || wr_modulo;
  end

  // external pin through synchroniser into edge pulses
  edge_sync pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(ext_count_pin),
    .rise_pulse(pin_rise),
    .fall_pulse(pin_fall)
  );

  // fixed frequency clock also arrives from another domain
  edge_sync fixed_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(fixed_freq_clock),
    .rise_pulse(fixed_rise),
    .fall_pulse()
  );

  // source multiplexer
  always_comb begin
    case (source_select)
      SRC_BUS: begin
        src_tick = 1'b1;
      end
      SRC_FIXED: begin
        src_tick = fixed_rise;
      end
      SRC_PIN_FALL: begin
        src_tick = pin_fall;
      end
      SRC_PIN_RISE: begin
        src_tick = pin_rise;
      end
      default: begin
        src_tick = 1'b1;
      end
    endcase
  end

  // divider; only a clear restarts it, never a source or ratio change
  prescaler divider (
    .core_clk(core_clk),
    .rst(rst),
    .src_tick(src_tick),
    .run(~count_halt),
    .clear(count_clear),
    .select(prescale_select),
    .tick_out(presc_tick)
  );

  // ************************************************************
  // counter and overflow flag
  // ************************************************************
  // next counter, flag and clearing sequence
  always_comb begin
    overflow_event = presc_tick && !count_clear && (count == count_limit(modulo));
    clear_seq = wr_status && !reg_wdata[BIT_OVF] && (clear_state == CLR_ARMED);
    next_count = count;
    if (count_clear) begin
      next_count = 8'h00;
    end else if (overflow_event) begin
      next_count = 8'h00;
    end else if (presc_tick) begin
      next_count = count + 8'h01;
    end
    // a new overflow beats the two-step clear in the same cycle; a count clear blocks the overflow
    next_overflow_flag = overflow_flag;
    if (overflow_event) begin
      next_overflow_flag = 1'b1;
    end else if (clear_seq || count_clear) begin
      next_overflow_flag = 1'b0;
    end
    // clearing sequence tracker
    next_clear_state = clear_state;
    case (clear_state)
      CLR_IDLE: begin
        if (rd_status && overflow_flag && !overflow_event) begin
          next_clear_state = CLR_ARMED;
        end
      end
      CLR_ARMED: begin
        if (overflow_event) begin
          next_clear_state = CLR_IDLE;
        end else if (wr_status) begin
          next_clear_state = CLR_IDLE;
        end
      end
      default: begin
        next_clear_state = CLR_IDLE;
      end
    endcase
  end

  // ************************************************************
  // software registers and read port
  // ************************************************************
  // control fields, modulo and read data
  always_comb begin
    next_overflow_irq_enable = overflow_irq_enable;
    next_count_halt = count_halt;
    next_source_select = source_select;
    next_prescale_select = prescale_select;
    next_modulo = modulo;
    if (wr_status) begin
      next_overflow_irq_enable = reg_wdata[BIT_IRQ_EN];
      next_count_halt = reg_wdata[BIT_HALT];
    end
    if (wr_clock) begin
      next_source_select = reg_wdata[SRC_HI:SRC_LO];
      next_prescale_select = reg_wdata[PS_HI:PS_LO];
    end
    if (wr_modulo) begin
      next_modulo = reg_wdata;
    end
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        OFS_STATUS: begin
          next_rdata = {overflow_flag, overflow_irq_enable, 1'b0, count_halt, 4'h0};
        end
        OFS_CLOCK: begin
          next_rdata = {2'h0, source_select, prescale_select};
        end
        OFS_COUNT: begin
          next_rdata = count;
        end
        OFS_MODULO: begin
          next_rdata = modulo;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
    next_irq = next_overflow_flag && next_overflow_irq_enable;
  end

  // register everything
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= RST_IRQ_EN;
      count_halt <= RST_HALT;
      source_select <= RST_SRC;
      prescale_select <= RST_PS;
      count <= RST_COUNT;
      modulo <= RST_MODULO;
      clear_state <= CLR_IDLE;
      rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      overflow_flag <= next_overflow_flag;
      overflow_irq_enable <= next_overflow_irq_enable;
      count_halt <= next_count_halt;
      source_select <= next_source_select;
      prescale_select <= next_prescale_select;
      count <= next_count;
      modulo <= next_modulo;
      clear_state <= next_clear_state;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  assign reg_rdata = rdata;
  assign overflow_irq = irq;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence seq_armed;
    clear_state == CLR_ARMED;
  endsequence

  sequence seq_zero_write;
    wr_status && !reg_wdata[BIT_OVF] && !overflow_event;
  endsequence

  sequence seq_status_read;
    rd_status && overflow_flag && !overflow_event;
  endsequence

  chk_irq_gating: assert property (
    overflow_irq == (overflow_flag && overflow_irq_enable))
    else $error("interrupt does not match flag and enable");

  chk_halt_holds: assert property (
    count_halt && !count_clear |=> count == $past(count))
    else $error("count moved while halted");

  chk_overflow_sets: assert property (
    overflow_event |=> overflow_flag && (count == 8'h00))
    else $error("overflow did not set flag and wrap count");

  chk_flag_no_set: assert property (
    !overflow_flag && !overflow_event |=> !overflow_flag)
    else $error("flag set without an overflow");

  chk_modulo_write: assert property (
    wr_modulo |=> !overflow_flag && (count == 8'h00) && (modulo == $past(reg_wdata)))
    else $error("modulo write did not clear count and flag");

  chk_reset_strobe: assert property (
    wr_status && reg_wdata[BIT_CLEAR] |=> !overflow_flag && (count == 8'h00))
    else $error("clear strobe did not reset count and flag");

  // a status read with the flag up arms the clear
  chk_read_arms: assert property (
    seq_status_read |=> seq_armed)
    else $error("status read did not arm the flag clear");

  chk_clear_sequence: assert property (
    seq_armed ##0 seq_zero_write |=> !overflow_flag)
    else $error("read then zero write did not clear flag");

  chk_void_clear: assert property (
    seq_armed ##0 overflow_event |=> overflow_flag ##0 (clear_state == CLR_IDLE))
    else $error("overflow did not void the clearing sequence");

  chk_unused_zero: assert property (
    reg_rd && (reg_addr == OFS_CLOCK) |=> reg_rdata[7:6] == 2'h0)
    else $error("unused clock bits read nonzero");

  chk_count_read: assert property (
    reg_rd && (reg_addr == OFS_COUNT) |=> (reg_rdata == $past(count))
      ##1 ((reg_rdata == 8'h00) || $past(reg_rd)))
    else $error("count read data wrong or held too long");

  chk_config_keeps: assert property (
    wr_clock && !count_clear && !presc_tick |=> count == $past(count))
    else $error("config write disturbed count");

endmodule : modulo_timer
`default_nettype wire

// ### ext_clock_model.sv
`default_nettype none
module ext_clock_model (
  input wire logic core_clk,
  output logic ext_count_pin,
  output logic fixed_freq_clock
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // slow external sources, idle low between bursts
  // ************************************************************
  initial begin
    ext_count_pin = 1'b0;
    fixed_freq_clock = 1'b0;
  end

  // n full pulses, 4 bus cycles per phase, eighth of bus rate
  task automatic pulses(input int n, input bit use_fixed);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      if (use_fixed) begin
        fixed_freq_clock <= 1'b1;
      end else begin
        ext_count_pin <= 1'b1;
      end
      repeat (4) @(posedge core_clk);
      if (use_fixed) begin
        fixed_freq_clock <= 1'b0;
      end else begin
        ext_count_pin <= 1'b0;
      end
    end
  endtask : pulses
endmodule : ext_clock_model
`default_nettype wire

// ### modulo_timer_tb.sv
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; `FAILMSG(g, e) end end
`define FAILMSG(g, e) $display("[FAIL] %0t got %h want %h", $time, g, e);
module modulo_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import modulo_timer_pkg::*;

  // ************************************************************
  // signals and counters
  // ************************************************************
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic overflow_irq;
  wire logic ext_count_pin;
  wire logic fixed_freq_clock;
  int num_errors = 0; // mismatches
  int checked = 0; // comparisons
  logic [7:0] v; // last read value

  // 25 MHz bus clock
  always #20 core_clk = ~core_clk;

  modulo_timer dut_u (
    .core_clk(core_clk), .rst(rst), .ext_count_pin(ext_count_pin),
    .fixed_freq_clock(fixed_freq_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .overflow_irq(overflow_irq)
  );

  ext_clock_model partner_u (
    .core_clk(core_clk), .ext_count_pin(ext_count_pin), .fixed_freq_clock(fixed_freq_clock)
  );

  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data taken in the cycle after the strobe only
  task automatic rd(input logic [1:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic results();
    $display("errors %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // ************************************************************
  // scenarios
  // ************************************************************
  // reset values, also after a second reset once all scenarios have run
  task automatic t_reset();
    rd(OFS_STATUS);
    `CHK(v, 8'h10)
    rd(OFS_CLOCK);
    `CHK(v, 8'h00)
    rd(OFS_COUNT);
    `CHK(v, 8'h00)
    rd(OFS_MODULO);
    `CHK(v, 8'h00)
    `CHK(overflow_irq, 1'b0)
  endtask : t_reset

  // ratio 4, then select above eight keeps count and divides by 256
  task automatic t_prescale();
    wr(OFS_COUNT, 8'h55);
    rd(OFS_COUNT);
    `CHK(v, 8'h00)
    wr(OFS_CLOCK, 8'hFF);
    rd(OFS_CLOCK);
    `CHK(v, 8'h3F)
    wr(OFS_CLOCK, 8'h02);
    wr(OFS_STATUS, 8'h30);
    wr(OFS_STATUS, 8'h00);
    repeat (40) @(posedge core_clk);
    wr(OFS_STATUS, 8'h10);
    rd(OFS_COUNT);
    `CHK(v >= 8'h09 && v <= 8'h0B, 1'b1)
    wr(OFS_CLOCK, 8'h09);
    wr(OFS_STATUS, 8'h00);
    repeat (512) @(posedge core_clk);
    wr(OFS_STATUS, 8'h10);
    rd(OFS_COUNT);
    `CHK(v >= 8'h0B && v <= 8'h0D, 1'b1)
    repeat (10) @(posedge core_clk);
    rd(OFS_COUNT);
    `CHK(v >= 8'h0B && v <= 8'h0D, 1'b1)
  endtask : t_prescale

  // modulo wrap, two-step flag clear, voided clear, irq and clear strobe
  task automatic t_overflow();
    wr(OFS_CLOCK, 8'h00);
    wr(OFS_MODULO, 8'h03);
    wr(OFS_STATUS, 8'h00);
    repeat (12) @(posedge core_clk);
    #1;
    `CHK(overflow_irq, 1'b0)
    wr(OFS_STATUS, 8'h10);
    rd(OFS_STATUS);
    `CHK(v, 8'h90)
    repeat (5) @(posedge core_clk);
    wr(OFS_STATUS, 8'h10);
    rd(OFS_STATUS);
    `CHK(v, 8'h10)
    wr(OFS_STATUS, 8'h90);
    rd(OFS_STATUS);
    `CHK(v, 8'h10)
    wr(OFS_STATUS, 8'h00);
    // read lands one cycle before a wrap, so the next wrap voids the armed clear
    repeat (11) @(posedge core_clk);
    rd(OFS_STATUS);
    `CHK(v[7], 1'b1)
    repeat (8) @(posedge core_clk);
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS);
    `CHK(v[7], 1'b1)
    wr(OFS_STATUS, 8'h10);
    wr(OFS_MODULO, 8'h03);
    rd(OFS_STATUS);
    `CHK(v, 8'h10)
    rd(OFS_COUNT);
    `CHK(v, 8'h00)
    wr(OFS_STATUS, 8'h40); // flag already cleared by the modulo write
    repeat (12) @(posedge core_clk);
    #1;
    `CHK(overflow_irq, 1'b1)
    wr(OFS_STATUS, 8'h70);
    rd(OFS_STATUS);
    `CHK(v, 8'h50)
    rd(OFS_COUNT);
    `CHK(v, 8'h00)
    `CHK(overflow_irq, 1'b0)
    wr(OFS_STATUS, 8'h30);
  endtask : t_overflow

  // pin rise, pin fall after a live source change, then fixed clock
  task automatic t_sources();
    wr(OFS_MODULO, 8'h00);
    wr(OFS_CLOCK, 8'h30);
    wr(OFS_STATUS, 8'h00);
    partner_u.pulses(5, 1'b0);
    repeat (8) @(posedge core_clk);
    wr(OFS_CLOCK, 8'h20);
    partner_u.pulses(3, 1'b0);
    repeat (8) @(posedge core_clk);
    wr(OFS_STATUS, 8'h10);
    rd(OFS_COUNT);
    `CHK(v, 8'h08)
    wr(OFS_CLOCK, 8'h10);
    wr(OFS_STATUS, 8'h00);
    partner_u.pulses(4, 1'b1);
    repeat (8) @(posedge core_clk);
    wr(OFS_STATUS, 8'h10);
    rd(OFS_COUNT);
    `CHK(v, 8'h0C)
  endtask : t_sources

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_prescale();
    t_overflow();
    t_sources();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    results();
  end

  // hang guard, far beyond the fewer than a thousand cycles needed
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    results();
  end
endmodule : modulo_timer_tb
`default_nettype wire
